// *** core/rgbp_seq.sv ***
`timescale 1ns/100ps
// Summary of operation
// [R1] Eight slots; first byte holds red in 7-5, green in 4-2, upper hold bits in 1-0.
// [R2] Second byte holds lower hold bits in 7-6, blue in 5-3, ramp code in 2-0.
// [R3] Colour codes map to 0,7,14,21,32,46,71,100 percent, or 0,1,2,4,10,21,46,100 with curve set.
// [R4] The 4-bit hold code decodes to 197 ms up to 3146 ms in steps near 196.6 ms.
// [R5] Ramp codes give 0,55,110,221,442,885,1770,3539 ms; code 0 changes at once.
// [R6] Audio speed field in bits 1-0 picks fastest, fast, medium, slow; fastest after reset.
// [R7] Audio averaging is applied only while bit 4 is set, otherwise bypassed.
// [R8] Bits 3-2 of the audio register hold the filtering mode.
// [R9] Setting start runs the pattern from slot 1; clearing it disables the generator.
// [R10] With loop set the pattern repeats until stopped, else it runs once.
// [R11] Each command ramps the colours to new levels, then advances after its hold time.
// [R12] Host fills the slots before start and leaves the active slot alone while running.
module rgbp_seq #(
	parameter int CYC_MS = rgbp_pkg::CYC_PER_MS
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// Register port
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Audio path
	input wire logic aud_valid,
	input wire logic [7:0] aud_sample,
	output logic [7:0] aud_out,
	output logic aud_avg_en,
	output logic [1:0] aud_filter_mode,
	output logic [1:0] aud_speed,
	// LED drive
	output logic [6:0] red_level,
	output logic [6:0] green_level,
	output logic [6:0] blue_level,
	output logic [2:0] pwm_out,
	output logic seq_busy
);
	logic [7:0] cmd_a_r [8];
	logic [7:0] cmd_b_r [8];
	logic [7:0] pgen_r;
	logic [7:0] aud2_r;
	logic [7:0] rdata_r;
	logic [7:0] avg_r;
	logic [7:0] aud_out_r;
	rgbp_pkg::rgbp_state_t st_r;
	logic [2:0] slot_r;
	logic start_prev_r;
	logic load_r;
	logic [31:0] div_r;
	rgbp_pkg::rgbp_ms_t ms_r;
	logic [6:0] pwm_cnt_r;
	logic [2:0] pwm_r;
	logic [7:0] cur_a;
	logic [7:0] cur_b;
	logic [3:0] hold_code;
	logic [2:0] code [3];
	logic ms_tick;
	logic adv;
	logic start;
	logic loop_en;
	logic curve;
	logic [8:0] avg_sum;
	logic [6:0] lvl [3];
	rgbp_pkg::rgbp_ms_t ramp_ms;

	assign start = pgen_r[rgbp_pkg::PGEN_START_BIT];
	assign loop_en = pgen_r[rgbp_pkg::PGEN_LOOP_BIT];
	assign curve = pgen_r[rgbp_pkg::PGEN_CURVE_BIT];

	// Slot contents are read live; the host keeps the active slot stable
	assign cur_a = cmd_a_r[slot_r]; // R12
	assign cur_b = cmd_b_r[slot_r];
	assign code[0] = cur_a[rgbp_pkg::RED_LSB +: rgbp_pkg::CODE_W]; // R1
	assign code[1] = cur_a[rgbp_pkg::GREEN_LSB +: rgbp_pkg::CODE_W]; // R1
	assign code[2] = cur_b[rgbp_pkg::BLUE_LSB +: rgbp_pkg::CODE_W]; // R2
	assign hold_code = {cur_a[rgbp_pkg::HOLD_HI_LSB +: 2], cur_b[rgbp_pkg::HOLD_LO_LSB +: 2]}; // R1 R2
	assign ramp_ms = rgbp_pkg::RAMP_MS[cur_b[rgbp_pkg::RAMP_LSB +: rgbp_pkg::CODE_W]]; // R2 R5
	assign ms_tick = (div_r == 32'(CYC_MS - 1));
	assign adv = ms_tick && (ms_r == rgbp_pkg::HOLD_MS[hold_code] - 12'h001); // R4

	// Register writes
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pgen_r <= rgbp_pkg::PGEN_RST;
			aud2_r <= rgbp_pkg::AUD2_RST; // R6
			for (int i = 0; i < 8; i++) begin
				cmd_a_r[i] <= rgbp_pkg::CMD_RST;
				cmd_b_r[i] <= rgbp_pkg::CMD_RST;
			end
		end else if (ce && reg_we) begin
			if (reg_addr == rgbp_pkg::ADDR_PGEN) begin
				pgen_r <= reg_wdata & rgbp_pkg::PGEN_MASK;
			end else if (reg_addr == rgbp_pkg::ADDR_AUD2) begin
				aud2_r <= reg_wdata & rgbp_pkg::AUD2_MASK; // R6 R7 R8
			end else if (reg_addr >= rgbp_pkg::ADDR_CMD_BASE && reg_addr <= rgbp_pkg::ADDR_CMD_LAST) begin
				if (reg_addr[0]) begin
					cmd_b_r[reg_addr[3:1]] <= reg_wdata;
				end else begin
					cmd_a_r[reg_addr[3:1]] <= reg_wdata;
				end
			end
		end
	end

	// Register reads, one cycle behind the address
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata_r <= 8'h00;
		end else if (ce) begin
			if (reg_addr == rgbp_pkg::ADDR_PGEN) begin
				rdata_r <= pgen_r;
			end else if (reg_addr == rgbp_pkg::ADDR_AUD2) begin
				rdata_r <= aud2_r;
			end else if (reg_addr == rgbp_pkg::ADDR_STAT) begin
				rdata_r <= {st_r == rgbp_pkg::ST_RUN, st_r == rgbp_pkg::ST_DONE, 3'h0, slot_r};
			end else if (reg_addr >= rgbp_pkg::ADDR_CMD_BASE && reg_addr <= rgbp_pkg::ADDR_CMD_LAST) begin
				rdata_r <= reg_addr[0] ? cmd_b_r[reg_addr[3:1]] : cmd_a_r[reg_addr[3:1]];
			end else begin
				rdata_r <= 8'h00;
			end
		end
	end

	// Sequencer
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_r <= rgbp_pkg::ST_IDLE;
			slot_r <= 3'h0;
			start_prev_r <= 1'b0;
			load_r <= 1'b0;
		end else if (ce) begin
			start_prev_r <= start;
			load_r <= 1'b0;
			case (st_r)
				rgbp_pkg::ST_IDLE: begin
					if (start && !start_prev_r) begin
						st_r <= rgbp_pkg::ST_RUN; // R9
						slot_r <= 3'h0;
						load_r <= 1'b1;
					end
				end
				rgbp_pkg::ST_RUN: begin
					if (!start) begin
						st_r <= rgbp_pkg::ST_IDLE; // R9
						load_r <= 1'b1;
					end else if (adv) begin // R11
						load_r <= 1'b1;
						if (slot_r != 3'h7) begin
							slot_r <= slot_r + 3'h1;
						end else if (loop_en) begin
							slot_r <= 3'h0; // R10
						end else begin
							st_r <= rgbp_pkg::ST_DONE; // R10
							load_r <= 1'b0;
						end
					end
				end
				rgbp_pkg::ST_DONE: begin
					// Last colour stays lit until start is cleared
					if (!start) begin
						st_r <= rgbp_pkg::ST_IDLE;
						load_r <= 1'b1;
					end
				end
				default: begin
					st_r <= rgbp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Hold timer: millisecond prescaler, restarted with each command
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			div_r <= 32'h00000000;
			ms_r <= 12'h000;
		end else if (ce) begin
			if (st_r != rgbp_pkg::ST_RUN || load_r || adv) begin
				div_r <= 32'h00000000;
				ms_r <= 12'h000;
			end else if (ms_tick) begin
				div_r <= 32'h00000000;
				ms_r <= ms_r + 12'h001; // R4
			end else begin
				div_r <= div_r + 32'h00000001;
			end
		end
	end

	// Audio averaging
	assign avg_sum = {1'b0, avg_r} + {1'b0, aud_sample};
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			avg_r <= 8'h00;
			aud_out_r <= 8'h00;
		end else if (ce && aud_valid) begin
			if (aud2_r[rgbp_pkg::AUD_AVG_BIT]) begin
				avg_r <= avg_sum[8:1]; // R7
				aud_out_r <= avg_sum[8:1];
			end else begin
				avg_r <= aud_sample; // R7
				aud_out_r <= aud_sample;
			end
		end
	end
	assign aud_out = aud_out_r;
	assign aud_avg_en = aud2_r[rgbp_pkg::AUD_AVG_BIT];
	assign aud_filter_mode = aud2_r[rgbp_pkg::AUD_MODE_LSB +: 2]; // R8
	assign aud_speed = aud2_r[rgbp_pkg::AUD_SPEED_LSB +: 2]; // R6

	// Shared PWM period counter, 100 steps
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pwm_cnt_r <= 7'h00;
		end else if (ce) begin
			pwm_cnt_r <= (pwm_cnt_r == rgbp_pkg::PWM_LAST) ? 7'h00 : pwm_cnt_r + 7'h01;
		end
	end

	rgbp_ramp_if rif[3] ();
	for (genvar gi = 0; gi < 3; gi++) begin : g_col
		// Stopping ramps to dark at once
		assign rif[gi].load = load_r;
		assign rif[gi].target = (st_r == rgbp_pkg::ST_RUN) ?
			(curve ? rgbp_pkg::LOG_PCT[code[gi]] : rgbp_pkg::LIN_PCT[code[gi]]) : 7'h00; // R3
		assign rif[gi].span = (st_r == rgbp_pkg::ST_RUN) ? 32'(ramp_ms) * 32'(CYC_MS) : 32'h00000000; // R5
		assign lvl[gi] = rif[gi].level;
		rgbp_ramp u_ramp (
			.mclk(mclk),
			.nrst(nrst),
			.ce(ce),
			.rp(rif[gi].rmp)
		);
		always_ff @(posedge mclk) begin
			if (!nrst) begin
				pwm_r[gi] <= 1'b0;
			end else if (ce) begin
				pwm_r[gi] <= (lvl[gi] > pwm_cnt_r);
			end
		end
	end

	assign red_level = lvl[0];
	assign green_level = lvl[1];
	assign blue_level = lvl[2];
	assign pwm_out = pwm_r;
	assign seq_busy = (st_r == rgbp_pkg::ST_RUN);
	assign reg_rdata = rdata_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_start_rise;
		ce && st_r == rgbp_pkg::ST_IDLE && start && !start_prev_r;
	endsequence
	sequence s_last_adv;
		ce && st_r == rgbp_pkg::ST_RUN && start && adv && slot_r == 3'h7;
	endsequence
	sequence s_aud_wr_rd;
		ce && reg_we && reg_addr == rgbp_pkg::ADDR_AUD2 ##1 ce && !reg_we && reg_addr == rgbp_pkg::ADDR_AUD2;
	endsequence

	AST_START: assert property (s_start_rise |=> st_r == rgbp_pkg::ST_RUN && slot_r == 3'h0 && load_r) // R9
		else $error("Start did not begin at slot one");
	AST_STOP: assert property (ce && !start && st_r != rgbp_pkg::ST_IDLE |=> st_r == rgbp_pkg::ST_IDLE && load_r) // R9
		else $error("Clearing start did not stop the generator");
	AST_LOOP: assert property (s_last_adv ##0 loop_en |=> st_r == rgbp_pkg::ST_RUN && slot_r == 3'h0) // R10
		else $error("Loop did not wrap to slot one");
	AST_ONCE: assert property (s_last_adv ##0 !loop_en |=> st_r == rgbp_pkg::ST_DONE ##1 st_r == rgbp_pkg::ST_DONE || !start) // R10
		else $error("Single pass did not finish");
	AST_HOLD: assert property (ce && st_r == rgbp_pkg::ST_RUN && start && !adv |=> slot_r == $past(slot_r)) // R4
		else $error("Slot advanced before hold time");
	AST_AUD_BYP: assert property (ce && aud_valid && !aud_avg_en |=> aud_out == $past(aud_sample)) // R7
		else $error("Averaging not bypassed");
	AST_AUD_AVG: assert property (ce && aud_valid && aud_avg_en |=> aud_out == $past(avg_sum[8:1])) // R7
		else $error("Averaging not applied");
	AST_AUD_RD: assert property (s_aud_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & rgbp_pkg::AUD2_MASK)) // R6
		else $error("Audio register readback wrong");
endmodule

// *** shared/rgbp_pkg.sv ***
package rgbp_pkg;
	localparam int CLK_MHZ = 250;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam logic [7:0] ADDR_PGEN = 8'h11;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam logic [7:0] ADDR_AUD2 = 8'h2b;
	localparam logic [7:0] ADDR_CMD_BASE = 8'h50;
	localparam logic [7:0] ADDR_CMD_LAST = 8'h5f;
	localparam int CODE_W = 3;
	localparam int RED_LSB = 5;
	localparam int GREEN_LSB = 2;
	localparam int HOLD_HI_LSB = 0;
	localparam int HOLD_LO_LSB = 6;
	localparam int BLUE_LSB = 3;
	localparam int RAMP_LSB = 0;
	localparam int PGEN_START_BIT = 2;
	localparam int PGEN_LOOP_BIT = 1;
	localparam int PGEN_CURVE_BIT = 0;
	localparam logic [7:0] PGEN_MASK = 8'h07;
	localparam int AUD_AVG_BIT = 4;
	localparam int AUD_MODE_LSB = 2;
	localparam int AUD_SPEED_LSB = 0;
	localparam logic [7:0] AUD2_MASK = 8'h1f;
	localparam logic [7:0] PGEN_RST = 8'h00;
	localparam logic [7:0] AUD2_RST = 8'h00;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [6:0] PWM_LAST = 7'h63;
	typedef logic [6:0] rgbp_pct_t;
	typedef logic [11:0] rgbp_ms_t;
	typedef enum {ST_IDLE, ST_RUN, ST_DONE} rgbp_state_t;
	localparam rgbp_pct_t LIN_PCT [8] = '{7'h00, 7'h07, 7'h0e, 7'h15, 7'h20, 7'h2e, 7'h47, 7'h64};
	localparam rgbp_pct_t LOG_PCT [8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0a, 7'h15, 7'h2e, 7'h64};
	localparam rgbp_ms_t HOLD_MS [16] = '{12'h0c5, 12'h189, 12'h24e, 12'h312, 12'h3d7, 12'h49c,
		12'h560, 12'h625, 12'h6e9, 12'h7ae, 12'h873, 12'h937, 12'h9fc, 12'hac1, 12'hb85, 12'hc4a};
	localparam rgbp_ms_t RAMP_MS [8] = '{12'h000, 12'h037, 12'h06e, 12'h0dd, 12'h1ba, 12'h375,
		12'h6ea, 12'hdd3};
endpackage

// *** shared/rgbp_ramp_if.sv ***
`timescale 1ns/100ps
interface rgbp_ramp_if;
	logic load;
	logic [6:0] target;
	logic [31:0] span;
	logic [6:0] level;
	modport ctl (output load, output target, output span, input level);
	modport rmp (input load, input target, input span, output level);
endinterface

// *** core/rgbp_ramp.sv ***
`timescale 1ns/100ps
module rgbp_ramp (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	// Control side
	rgbp_ramp_if.rmp rp
);
	logic [6:0] level_r;
	logic [6:0] tgt_r;
	logic [6:0] diff_r;
	logic [31:0] span_r;
	logic [31:0] acc_r;
	logic [31:0] acc_sum;

	// Spreads diff steps evenly over span cycles; at most one step a cycle
	assign acc_sum = acc_r + {25'h0000000, diff_r};
	assign rp.level = level_r;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			level_r <= 7'h00;
			tgt_r <= 7'h00;
			diff_r <= 7'h00;
			span_r <= 32'h00000000;
			acc_r <= 32'h00000000;
		end else if (ce) begin
			if (rp.load) begin
				tgt_r <= rp.target;
				span_r <= rp.span;
				acc_r <= 32'h00000000;
				diff_r <= (rp.target > level_r) ? rp.target - level_r : level_r - rp.target;
				if (rp.span == 32'h00000000) begin
					level_r <= rp.target; // R5
				end
			end else if (level_r != tgt_r) begin // R11
				if (acc_sum >= span_r) begin
					level_r <= (tgt_r > level_r) ? level_r + 7'h01 : level_r - 7'h01;
					acc_r <= acc_sum - span_r;
				end else begin
					acc_r <= acc_sum;
				end
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_RAMP_IMM: assert property (ce && rp.load && rp.span == 32'h00000000 |=> level_r == $past(rp.target)) // R5
		else $error("Zero ramp code did not jump to target");
	AST_RAMP_STEP: assert property (!$past(rp.load) |-> (level_r - $past(level_r) <= 7'h01) || ($past(level_r) - level_r <= 7'h01)) // R11
		else $error("Ramp moved more than one step");
endmodule

// *** bench/rgbp_host.sv ***
`timescale 1ns/100ps
module rgbp_host (
	// Clock
	input wire logic mclk,
	// Register port
	output logic reg_we,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_we = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Call just after an edge; one taken edge, then an idle edge
	// So back-to-back calls never retoggle a pin in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(posedge mclk);
		#1 reg_we = 1'b0;
		reg_wdata = ~d;
		@(posedge mclk);
		#1;
	endtask
	// Two edges so the registered read data has settled on this address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		repeat (2) @(posedge mclk);
		#1 d = reg_rdata;
	endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	// Short millisecond keeps a full eight-slot pass near 6300 cycles
	localparam int CMS = 4;
	localparam int SLOT = 197 * CMS;
	localparam logic [23:0] ROWS [8] = '{24'h2bff1f, 24'h2b0a0a, 24'h50a5a5, 24'h515a5a,
		24'h5fc3c3, 24'h110303, 24'h30ff00, 24'h14ff00};
	logic mclk, nrst, ce, aud_valid, reg_we, aud_avg_en, seq_busy;
	logic [7:0] aud_sample, rd_v, reg_addr, reg_wdata, reg_rdata, aud_out;
	logic [1:0] aud_filter_mode, aud_speed;
	logic [6:0] red_level, green_level, blue_level;
	logic [2:0] pwm_out;
	int err_count, checks_done, t0, n_g, n_b;
	int cyc = 0;

	rgbp_host host_u (.mclk, .reg_we, .reg_addr, .reg_wdata, .reg_rdata);
	rgbp_seq #(.CYC_MS(CMS)) dut_u (.mclk, .nrst, .ce, .reg_we, .reg_addr, .reg_wdata,
		.reg_rdata, .aud_valid, .aud_sample, .aud_out, .aud_avg_en, .aud_filter_mode,
		.aud_speed, .red_level, .green_level, .blue_level, .pwm_out, .seq_busy);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	task automatic complete_run();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t mismatch got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wait_busy(input logic v, input int lim);
		int n;
		n = 0;
		while (seq_busy !== v && n < lim) begin
			tick(1);
			n++;
		end
		if (seq_busy !== v) begin
			err_count++;
			$display("[FAIL] %0t busy wait ran out", $time);
			complete_run();
		end
	endtask
	task automatic aud_send(input logic [7:0] s);
		aud_valid = 1'b1;
		aud_sample = s;
		tick(1);
		aud_valid = 1'b0;
		aud_sample = ~s;
		tick(1);
	endtask

	initial begin
		#400000;
		err_count++;
		$display("[FAIL] %0t run took too long", $time);
		complete_run();
	end

	initial begin
		ce = 1'b1;
		nrst = 1'b0;
		aud_valid = 1'b0;
		aud_sample = 8'h00;
		err_count = 0;
		checks_done = 0;
		tick(6);
		nrst = 1'b1;
		host_u.rd(8'h2b, rd_v);
		chk(rd_v, 8'h00);
		host_u.rd(8'h50, rd_v);
		chk(rd_v, 8'h00);
		chk({6'h00, aud_speed}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			host_u.wr(ROWS[i][23:16], ROWS[i][15:8]);
			host_u.rd(ROWS[i][23:16], rd_v);
			chk(rd_v, ROWS[i][7:0]);
		end
		for (int i = 0; i < 4; i++) begin
			host_u.wr(8'h2b, {3'h0, 1'(i % 2), 2'(3 - i), 2'(i)});
			tick(1);
			chk({3'h0, aud_avg_en, aud_filter_mode, aud_speed},
				{3'h0, 1'(i % 2), 2'(3 - i), 2'(i)});
		end
		host_u.wr(8'h2b, 8'h00);
		aud_send(8'h40);
		chk(aud_out, 8'h40);
		host_u.wr(8'h2b, 8'h10);
		aud_send(8'h80);
		chk(aud_out, 8'h60);
		host_u.wr(8'h2b, 8'h00);
		aud_send(8'h11);
		chk(aud_out, 8'h11);
		// Slot 0 full red, mid green, dim blue, instant; the rest fade over 55 ms
		host_u.wr(8'h50, 8'hf0);
		host_u.wr(8'h51, 8'h08);
		for (int i = 1; i < 8; i++) begin
			host_u.wr(8'(8'h50 + 2 * i), 8'h40);
			host_u.wr(8'(8'h51 + 2 * i), 8'h01);
		end
		host_u.wr(8'h11, 8'h04);
		wait_busy(1'b1, 8);
		t0 = cyc;
		tick(2);
		chk({1'b0, red_level}, 8'h64);
		chk({1'b0, green_level}, 8'h20);
		chk({1'b0, blue_level}, 8'h07);
		chk({7'h00, pwm_out[0]}, 8'h01);
		// One full counter period gives the duty in percent
		n_g = 0;
		n_b = 0;
		for (int i = 0; i < 100; i++) begin
			n_g += int'(pwm_out[1]);
			n_b += int'(pwm_out[2]);
			tick(1);
		end
		chk(8'(n_g), 8'h20);
		chk(8'(n_b), 8'h07);
		host_u.rd(8'h14, rd_v);
		chk(rd_v, 8'h80);
		while (red_level === 7'h64 && cyc - t0 < SLOT + 20) tick(1);
		chk(8'(cyc - t0 >= SLOT && cyc - t0 <= SLOT + 5), 8'h01);
		tick(100);
		chk(8'(red_level > 7'h0e && red_level < 7'h64), 8'h01);
		tick(130);
		chk({1'b0, red_level}, 8'h0e);
		chk({1'b0, green_level}, 8'h00);
		chk({1'b0, blue_level}, 8'h00);
		wait_busy(1'b0, 7 * SLOT);
		chk(8'(cyc - t0 > 8 * SLOT), 8'h01);
		chk({1'b0, red_level}, 8'h0e);
		host_u.rd(8'h14, rd_v);
		chk(rd_v & 8'h40, 8'h40);
		host_u.wr(8'h11, 8'h00);
		tick(2);
		chk({1'b0, red_level}, 8'h00);
		host_u.wr(8'h11, 8'h07);
		wait_busy(1'b1, 8);
		tick(2);
		chk({1'b0, green_level}, 8'h0a);
		chk({1'b0, blue_level}, 8'h01);
		// Low enable freezes the run and drops writes
		ce = 1'b0;
		host_u.wr(8'h2b, 8'h03);
		tick(20);
		chk({5'h00, seq_busy, aud_speed}, 8'h04);
		chk({1'b0, green_level}, 8'h0a);
		ce = 1'b1;
		tick(8 * SLOT + 50);
		chk({7'h00, seq_busy}, 8'h01);
		host_u.wr(8'h11, 8'h03);
		tick(2);
		chk({6'h00, seq_busy, red_level === 7'h00}, 8'h01);
		// Reset in mid-run drops the pattern and the registers
		host_u.wr(8'h2b, 8'h1f);
		host_u.wr(8'h11, 8'h04);
		wait_busy(1'b1, 8);
		tick(2);
		nrst = 1'b0;
		tick(2);
		nrst = 1'b1;
		chk({5'h00, seq_busy, aud_speed}, 8'h00);
		chk({1'b0, red_level}, 8'h00);
		host_u.rd(8'h11, rd_v);
		chk(rd_v, 8'h00);
		complete_run();
	end
endmodule
